// [rtl/ltu_timer_regs.vh]
// register offsets, field positions, reset values and timing counts of the light timer unit
`ifndef LTU_TIMER_REGS_VH
`define LTU_TIMER_REGS_VH

// =====================================================================
// register offsets
`define LTU_OFS_TB2_CSR      8'h0C
`define LTU_OFS_RELOAD       8'h0D
`define LTU_OFS_LIVE_COUNT   8'h0E
`define LTU_OFS_TB1_CSR      8'h0F
`define LTU_OFS_CAPTURE      8'h10

// =====================================================================
// timebase2_ctrl_status fields
`define LTU_TB2_FLAG_BIT     0
`define LTU_TB2_IE_BIT       1

// =====================================================================
// timebase1_capture_ctrl_status fields
`define LTU_TB1_FLAG_BIT     3
`define LTU_TB1_IE_BIT       4
`define LTU_PERIOD_DBL_BIT   5
`define LTU_CAP_FLAG_BIT     6
`define LTU_CAP_IE_BIT       7

// =====================================================================
// reset values
`define LTU_RST_BYTE         8'h00
`define LTU_RST_BIT          1'b0

// =====================================================================
// timing counts in oscillator cycles
`define LTU_PRESCALE         32
`define LTU_PRESCALE_W       5
`define LTU_CNT1_LAST        8'hF9
`define LTU_CNT2_LAST        8'hFF
`define LTU_TB1_PERIOD       8000
`define LTU_TB1_PERIOD_DBL   16000

`endif

// [rtl/ltu_timer.v]
// light timer unit: two timebase counters, an input capture and a byte register port
//
// Contract
// - counter 1 starts at zero after reset, steps every 32 clocks, hidden from software.
// - counter 1 wraps from F9h to 00h; each wrap is one overflow.
// - timebase 1 period is 8000 clocks, or 16000 with period double select.
// - timebase 1 overflow sets its flag; flag and enable raise its request.
// - reading the timebase 1 status register clears its flag; writes leave it.
// - capture pin edge copies counter 1, sets capture flag, requests if enabled.
// - reading the capture register clears the capture flag; writes leave it.
// - capture edges are ignored while the capture flag is set.
// - counter 2 starts from the reload value after reset, steps every 32 clocks.
// - counter 2 past FFh loads the reload value; that is its overflow.
// - reload writes take effect only at the next counter 2 overflow.
// - counter 2 overflow sets its flag; flag and enable raise its request.
// - reading the timebase 2 status register clears its flag; writes set only its enable.
// - counter 2 live value is readable, read only.
// - halt stops both counters; other low power modes leave the timer running.
// - three separate request lines: timebase 1, timebase 2, capture.
// - capture register reads zero after reset and cannot be written.
`default_nettype none
`include "ltu_timer_regs.vh"

module ltu_timer #(
  parameter ADDR_W = 8
) (
  input  wire              sys_clk_i,
  input  wire              reset_n_i,
  input  wire [ADDR_W-1:0] addr_i,
  input  wire [7:0]        wr_data_i,
  input  wire              wr_en_i,
  input  wire              rd_en_i,
  output reg  [7:0]        rd_data_o,
  input  wire              halt_i,
  input  wire              capture_input_pin_i,
  output reg               irq_tb1_o,
  output reg               irq_tb2_o,
  output reg               irq_cap_o
);

  // =====================================================================
  // address decode
  function sel;
    input [ADDR_W-1:0] a;
    input [7:0]        ofs;
    begin
      sel = (a == ofs[ADDR_W-1:0]);
    end
  endfunction

  wire rd_tb1_csr = rd_en_i & sel(addr_i, `LTU_OFS_TB1_CSR);
  wire rd_tb2_csr = rd_en_i & sel(addr_i, `LTU_OFS_TB2_CSR);
  wire rd_capture = rd_en_i & sel(addr_i, `LTU_OFS_CAPTURE);
  wire wr_tb1_csr = wr_en_i & sel(addr_i, `LTU_OFS_TB1_CSR);
  wire wr_tb2_csr = wr_en_i & sel(addr_i, `LTU_OFS_TB2_CSR);
  wire wr_reload  = wr_en_i & sel(addr_i, `LTU_OFS_RELOAD);

  // =====================================================================
  // state
  reg [`LTU_PRESCALE_W-1:0] prescale;
  reg [7:0]                 counter1;
  reg                       half_period;
  reg [7:0]                 counter2;
  reg [7:0]                 reload_value_field;
  reg [7:0]                 captured_value_field;
  reg                       first_timebase_flag;
  reg                       first_timebase_irq_enable;
  reg                       period_double_select;
  reg                       second_timebase_flag;
  reg                       second_timebase_irq_enable;
  reg                       capture_flag;
  reg                       capture_irq_enable;
  reg                       pin_s1;
  reg                       pin_s2;
  reg                       pin_s3;

  // =====================================================================
  // prescaler and overflow events
  wire tick      = (prescale == `LTU_PRESCALE_W'h1F) & ~halt_i;
  wire wrap1     = tick & (counter1 == `LTU_CNT1_LAST);
  wire tb1_event = wrap1 & (~period_double_select | half_period);
  wire tb2_event = tick & (counter2 == `LTU_CNT2_LAST);
  wire pin_edge  = pin_s2 ^ pin_s3;
  wire cap_event = pin_edge & ~capture_flag;

  wire next_first_timebase_flag  = tb1_event | (first_timebase_flag & ~rd_tb1_csr);
  wire next_second_timebase_flag = tb2_event | (second_timebase_flag & ~rd_tb2_csr);
  wire next_capture_flag         = cap_event | (capture_flag & ~rd_capture);

  // =====================================================================
  // counters
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prescale    <= {`LTU_PRESCALE_W{1'b0}};
      counter1    <= `LTU_RST_BYTE;
      half_period <= `LTU_RST_BIT;
      counter2    <= `LTU_RST_BYTE;
    end else begin
      if (!halt_i) begin
        prescale <= prescale + `LTU_PRESCALE_W'h01;
      end
      if (tick) begin
        if (wrap1) begin
          counter1 <= 8'h00;
        end else begin
          counter1 <= counter1 + 8'h01;
        end
        if (tb2_event) begin
          counter2 <= reload_value_field;
        end else begin
          counter2 <= counter2 + 8'h01;
        end
      end
      if (wrap1) begin
        half_period <= ~half_period;
      end
    end
  end

  // =====================================================================
  // capture pin synchroniser
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1 <= `LTU_RST_BIT;
      pin_s2 <= `LTU_RST_BIT;
      pin_s3 <= `LTU_RST_BIT;
    end else begin
      pin_s1 <= capture_input_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // =====================================================================
  // software registers and flags
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reload_value_field         <= `LTU_RST_BYTE;
      captured_value_field       <= `LTU_RST_BYTE;
      first_timebase_flag        <= `LTU_RST_BIT;
      first_timebase_irq_enable  <= `LTU_RST_BIT;
      period_double_select       <= `LTU_RST_BIT;
      second_timebase_flag       <= `LTU_RST_BIT;
      second_timebase_irq_enable <= `LTU_RST_BIT;
      capture_flag               <= `LTU_RST_BIT;
      capture_irq_enable         <= `LTU_RST_BIT;
    end else begin
      if (wr_reload) begin
        reload_value_field <= wr_data_i;
      end
      if (wr_tb1_csr) begin
        capture_irq_enable        <= wr_data_i[`LTU_CAP_IE_BIT];
        period_double_select      <= wr_data_i[`LTU_PERIOD_DBL_BIT];
        first_timebase_irq_enable <= wr_data_i[`LTU_TB1_IE_BIT];
      end
      if (wr_tb2_csr) begin
        second_timebase_irq_enable <= wr_data_i[`LTU_TB2_IE_BIT];
      end
      if (cap_event) begin
        captured_value_field <= counter1;
      end
      first_timebase_flag  <= next_first_timebase_flag;
      second_timebase_flag <= next_second_timebase_flag;
      capture_flag         <= next_capture_flag;
    end
  end

  // =====================================================================
  // interrupt request lines
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_tb1_o <= `LTU_RST_BIT;
      irq_tb2_o <= `LTU_RST_BIT;
      irq_cap_o <= `LTU_RST_BIT;
    end else begin
      irq_tb1_o <= next_first_timebase_flag & first_timebase_irq_enable;
      irq_tb2_o <= next_second_timebase_flag & second_timebase_irq_enable;
      irq_cap_o <= next_capture_flag & capture_irq_enable;
    end
  end

  // =====================================================================
  // read data, one cycle after the strobe
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= `LTU_RST_BYTE;
    end else if (rd_en_i) begin
      rd_data_o <= 8'h00;
      if (sel(addr_i, `LTU_OFS_TB2_CSR)) begin
        rd_data_o[`LTU_TB2_IE_BIT]   <= second_timebase_irq_enable;
        rd_data_o[`LTU_TB2_FLAG_BIT] <= second_timebase_flag;
      end else if (sel(addr_i, `LTU_OFS_RELOAD)) begin
        rd_data_o <= reload_value_field;
      end else if (sel(addr_i, `LTU_OFS_LIVE_COUNT)) begin
        rd_data_o <= counter2;
      end else if (sel(addr_i, `LTU_OFS_TB1_CSR)) begin
        rd_data_o[`LTU_CAP_IE_BIT]     <= capture_irq_enable;
        rd_data_o[`LTU_CAP_FLAG_BIT]   <= capture_flag;
        rd_data_o[`LTU_PERIOD_DBL_BIT] <= period_double_select;
        rd_data_o[`LTU_TB1_IE_BIT]     <= first_timebase_irq_enable;
        rd_data_o[`LTU_TB1_FLAG_BIT]   <= first_timebase_flag;
      end else if (sel(addr_i, `LTU_OFS_CAPTURE)) begin
        rd_data_o <= captured_value_field;
      end
    end else begin
      rd_data_o <= 8'h00;
    end
  end

endmodule // ltu_timer
`default_nettype wire

// [verification/ltu_timer_sva.sv]
// port assertions for the light timer unit
`default_nettype none
module ltu_timer_sva #(
  parameter ADDR_W = 8
) (
  input wire logic              sys_clk_i,
  input wire logic              reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0]        wr_data_i,
  input wire logic              wr_en_i,
  input wire logic              rd_en_i,
  input wire logic [7:0]        rd_data_o,
  input wire logic              halt_i,
  input wire logic              capture_input_pin_i,
  input wire logic              irq_tb1_o,
  input wire logic              irq_tb2_o,
  input wire logic              irq_cap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // running clocks modulo one timebase period
  logic [15:0] run_cnt;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) run_cnt <= 16'h0000;
    else if (!halt_i) run_cnt <= (run_cnt == 16'h1F3F) ? 16'h0000 : run_cnt + 16'h0001;
  end
  // ==========================================
  // assertions
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_rd_data_stands: assert property (!$past(rd_en_i) |-> rd_data_o == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_unmapped_zero: assert property (rd_en_i && addr_i > 8'h10 |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (rd_en_i && addr_i == 8'h0C |=> rd_data_o[7:2] == 6'h00)
    else $error("reserved bits not zero");
  a_tb1_read_clear: assert property (rd_en_i && addr_i == 8'h0F |-> ##2 !irq_tb1_o)
    else $error("timebase 1 request not cleared by read");
  a_tb2_read_clear: assert property (rd_en_i && addr_i == 8'h0C |-> ##2 !irq_tb2_o)
    else $error("timebase 2 request not cleared by read");
  a_cap_read_clear: assert property (rd_en_i && addr_i == 8'h10 |-> ##2 !irq_cap_o)
    else $error("capture request not cleared by read");
  a_tb1_cadence: assert property ($rose(irq_tb1_o) && !$past(wr_en_i, 2) |-> run_cnt == 16'h0000)
    else $error("timebase 1 event off its period");
  a_halt_no_tick: assert property ($rose(irq_tb2_o) && !$past(wr_en_i, 2) |-> !$past(halt_i))
    else $error("timebase 2 event while halted");
  c_tb1: cover property ($rose(irq_tb1_o));
  c_tb2: cover property ($rose(irq_tb2_o));
  c_cap: cover property ($rose(irq_cap_o));
endmodule // ltu_timer_sva
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the light timer unit
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam ADDR_W = 8;
  logic        sys_clk_i, reset_n_i, wr_en_i, rd_en_i, halt_i, pin;
  logic [7:0]  addr_i, wr_data_i, rd_data_o, v, e;
  logic        irq_tb1_o, irq_tb2_o, irq_cap_o;
  logic [15:0] gap;
  int          err_count, comparisons, n, cyc, c, t0;
  wire logic [2:0] irqs = {irq_cap_o, irq_tb2_o, irq_tb1_o};
  ltu_timer #(.ADDR_W(ADDR_W)) uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .halt_i(halt_i), .capture_input_pin_i(pin),
    .irq_tb1_o(irq_tb1_o), .irq_tb2_o(irq_tb2_o), .irq_cap_o(irq_cap_o));
  // ==========================================
  // clock, cycle counts and bus tasks
  initial begin
    sys_clk_i = 1'h0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (reset_n_i && !halt_i) n <= n + 1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'h1;
    @(posedge sys_clk_i);
    wr_en_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_en_i <= 1'h1;
    @(posedge sys_clk_i);
    rd_en_i <= 1'h0;
    @(negedge sys_clk_i);
    v = rd_data_o;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic wrise(input int k);
    c = 0;
    repeat (2) @(negedge sys_clk_i);
    while (irqs[k] !== 1'h1 && c < 20000) begin
      @(negedge sys_clk_i);
      c++;
    end
    if (c >= 20000) err_count++;
    gap = 16'(cyc - t0);
    t0 = cyc;
  endtask
  task automatic complete_run;
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    err_count++;
    complete_run;
  end
  // ==========================================
  // tests
  initial begin
    {reset_n_i, wr_en_i, rd_en_i, halt_i, pin, addr_i, wr_data_i} = '0;
    {err_count, comparisons, n, cyc, t0} = '0;
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'h1;
    rd(8'h0C); chk(v, 8'h00);
    rd(8'h0D); chk(v, 8'h00);
    rd(8'h0E); chk(v, 8'h00);
    rd(8'h0F); chk(v & 8'hBF, 8'h00);
    rd(8'h10); chk(v, 8'h00);
    rd(8'h11); chk(v, 8'h00);
    wr(8'h0D, 8'hF0);
    wr(8'h0E, 8'h55);
    rd(8'h0E); chk(v, 8'h00);
    rd(8'h0D); chk(v, 8'hF0);
    $display("registers done");
    wr(8'h0F, 8'h10);
    wrise(0); rd(8'h0F); chk(v, 8'h18);
    wrise(0); chk(gap, 16'h1F40);
    rd(8'h0F); wr(8'h0F, 8'h30);
    wrise(0); rd(8'h0F);
    wrise(0); chk(gap, 16'h3E80);
    rd(8'h0F); chk(v, 8'h38);
    $display("timebase 1 done");
    wr(8'h0C, 8'h02);
    wrise(1); rd(8'h0C); chk(v, 8'h03);
    wrise(1); rd(8'h0C); chk(v, 8'h03);
    wrise(1); chk(gap, 16'h0200);
    rd(8'h0E); chk(v, 8'hF0);
    e = v;
    @(posedge sys_clk_i) halt_i <= 1'h1;
    repeat (100) @(posedge sys_clk_i);
    rd(8'h0E); chk(v, e);
    @(posedge sys_clk_i) halt_i <= 1'h0;
    $display("timebase 2 done");
    wr(8'h0F, 8'h80);
    rd(8'h10);
    do @(negedge sys_clk_i); while (n % 32 != 8);
    e = 8'((n / 32) % 250);
    @(posedge sys_clk_i) pin <= ~pin;
    wrise(2); rd(8'h0F); chk(v & 8'hC0, 8'hC0);
    @(posedge sys_clk_i) pin <= ~pin;
    repeat (300) @(posedge sys_clk_i);
    wr(8'h10, 8'h55);
    rd(8'h10); chk(v, e);
    repeat (20) @(negedge sys_clk_i);
    chk(16'(irq_cap_o), 16'h0000);
    $display("capture done");
    complete_run;
  end
endmodule // tb
bind ltu_timer ltu_timer_sva #(.ADDR_W(ADDR_W)) u_sva (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .halt_i(halt_i),
  .capture_input_pin_i(capture_input_pin_i), .irq_tb1_o(irq_tb1_o),
  .irq_tb2_o(irq_tb2_o), .irq_cap_o(irq_cap_o));
`default_nettype wire
